//--- verilog/pfr_pkg.sv
package pfr_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned TICK_TIME_US = 1000;
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_TIME_US;
	localparam int unsigned STEP_TIME_MS = 2;
	localparam int unsigned STEP_TICKS = STEP_TIME_MS * 1000 / TICK_TIME_US;
	localparam int unsigned DB_TIME_MS = 10;
	localparam int unsigned DB_TICKS = DB_TIME_MS * 1000 / TICK_TIME_US;
	localparam int unsigned WDT_TIME_MS = 2000;
	localparam int unsigned WDT_TICKS = WDT_TIME_MS * 1000 / TICK_TIME_US;

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int unsigned N_SUPPLY = 6;
	localparam int unsigned RETRY_W = 4;
	localparam logic [RETRY_W-1:0] RETRY_INIT = 4'h3;
	localparam logic [1:0] MASK_RST = 2'h0;

	// ------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_EVENT = 8'h08;
	localparam logic [7:0] A_MASK = 8'h0C;
	localparam logic [7:0] A_FAULT = 8'h10;
	localparam int unsigned CTRL_SYSEN = 0;
	localparam int unsigned CTRL_KICK = 1;
	localparam int unsigned EV_TWARN = 0;
	localparam int unsigned EV_WDT = 1;
	localparam int unsigned FL_TCRIT = 0;
	localparam int unsigned FL_WDT = 1;
	localparam int unsigned FL_POR = 2;

	// ------------------------------------------------------------
	// Sequencer modes
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		S_RESET = 7'h01,
		S_OFF = 7'h02,
		S_PUP1 = 7'h04,
		S_PUP2 = 7'h08,
		S_RUN = 7'h10,
		S_ACT = 7'h20,
		S_PDN = 7'h40
	} pfr_state_e;
endpackage : pfr_pkg

//--- verilog/pfr_tick.sv
module pfr_tick import pfr_pkg::*; #(
	parameter int unsigned DIV = TICK_CYC
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	output logic o_tick
);
	localparam int unsigned W = $clog2(DIV + 1);
	logic [W-1:0] cnt_q, cnt_d;
	logic tick_d;

	always_comb begin
		cnt_d = cnt_q + 1'b1;
		tick_d = 1'b0;
		if (cnt_q == W'(DIV - 1)) begin
			cnt_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_tick <= tick_d;
		end
	end
endmodule : pfr_tick

//--- verilog/pfr_sync.sv
module pfr_sync import pfr_pkg::*; #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DB = 0
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_tick,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_level
);
	localparam int unsigned CW = $clog2(DB + 2);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// agreed level, then held stable for DB ticks
	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		logic [CW-1:0] cnt_q, cnt_d;
		logic lvl_d;
		always_comb begin
			cnt_d = cnt_q;
			lvl_d = o_level[g];
			if (s2_q[g] != s3_q[g] || s3_q[g] == o_level[g]) begin
				cnt_d = '0;
			end else if (cnt_q >= CW'(DB)) begin
				lvl_d = s3_q[g];
				cnt_d = '0;
			end else if (i_tick) begin
				cnt_d = cnt_q + 1'b1;
			end
		end
		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				cnt_q <= '0;
				o_level[g] <= 1'b0;
			end else begin
				cnt_q <= cnt_d;
				o_level[g] <= lvl_d;
			end
		end
	end
endmodule : pfr_sync

//--- verilog/pfr_seq.sv
// Local design decisions: register access over APB and the register addresses.
module pfr_seq import pfr_pkg::*; #(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned WDT_MAX = WDT_TICKS,
	parameter int unsigned NSUP = N_SUPPLY,
	parameter logic [RETRY_W-1:0] RETRY_START = RETRY_INIT
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_wake_input_pin,
	input wire logic i_power_enable_input_pin,
	input wire logic i_temp_warn_cmp,
	input wire logic i_temp_critical_threshold_cmp,
	input wire logic i_temp_por_cmp,
	output logic o_forwarded_wake_output_pin,
	output logic o_core_reset_output_pin_n,
	output logic [NSUP-1:0] o_supply_en,
	output logic o_always_on_regulator_en,
	output logic o_system_en,
	output logic o_interrupt_request_out_n
);
	localparam int unsigned WW = $clog2(WDT_MAX + 1);
	localparam int unsigned SW = $clog2(STEP_TICKS + 1);

	// ------------------------------------------------------------
	// Tick and input conditioning
	// ------------------------------------------------------------
	logic tick;
	logic [1:0] pin_lvl;
	logic [2:0] tmp_lvl;
	logic wake, pen, warn, crit, por;

	pfr_tick #(.DIV(TICK_CYCLES)) u_tick (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.o_tick(tick)
	);

	pfr_sync #(.WIDTH(2), .DB(DB_TICKS)) u_pins (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_async({i_power_enable_input_pin, i_wake_input_pin}),
		.o_level(pin_lvl)
	);

	// Thresholds are not debounced: power-on reset must act at once
	pfr_sync #(.WIDTH(3), .DB(0)) u_temp (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_tick(tick),
		.i_async({i_temp_por_cmp, i_temp_critical_threshold_cmp, i_temp_warn_cmp}),
		.o_level(tmp_lvl)
	);

	assign wake = pin_lvl[0];
	assign pen = pin_lvl[1];
	assign warn = tmp_lvl[0];
	assign crit = tmp_lvl[1];
	assign por = tmp_lvl[2];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	pfr_state_e st_q, st_d;
	logic dest_q, dest_d;
	logic [SW-1:0] stk_q, stk_d;
	logic [NSUP-1:0] sup_q, sup_d;
	logic sysen_q, sysen_d, crst_n_q, crst_n_d, aon_q, aon_d, frz_q, frz_d;
	logic [RETRY_W-1:0] rty_q, rty_d;
	logic [WW-1:0] wdt_q, wdt_d;
	logic [1:0] ev_q, ev_d, msk_q, msk_d;
	logic [2:0] flt_q, flt_d, prv_q;
	logic irq_n_q, irq_n_d, fwd_q;
	logic [31:0] rdat_q, rdat_d;
	logic rdy_q, rdy_d, err_q, err_d;
	logic acc, wr, kick, live, powered, wdt_exp, step;
	logic warn_rise, crit_rise, wake_fall;

	assign acc = i_psel & i_penable & rdy_q;
	assign wr = acc & i_pwrite & ~err_q;
	assign kick = wr && i_paddr == A_CTRL && i_pwdata[CTRL_KICK];
	assign live = st_q == S_RUN || st_q == S_ACT;
	assign powered = live || st_q == S_PUP1 || st_q == S_PUP2;
	assign wdt_exp = live && wdt_q == WW'(WDT_MAX);
	assign step = tick && stk_q == SW'(STEP_TICKS - 1);
	assign warn_rise = warn & ~prv_q[1];
	assign crit_rise = crit & ~prv_q[2];
	assign wake_fall = ~wake & prv_q[0];

	// ------------------------------------------------------------
	// APB slave: zero-wait access phase, read data sampled at setup, write data in the access phase
	// ------------------------------------------------------------
	always_comb begin
		rdy_d = i_psel & ~i_penable;
		rdat_d = rdat_q;
		// Error is registered for the access cycle only, so the port comes straight from a flop
		err_d = 1'b0;
		if (rdy_d) begin
			rdat_d = 32'h0;
			err_d = 1'b0;
			if (i_paddr == A_CTRL) begin
				rdat_d[CTRL_SYSEN] = sysen_q;
			end else if (i_paddr == A_STAT) begin
				rdat_d = {18'h0, wake, frz_q, rty_q, 1'b0, st_q};
			end else if (i_paddr == A_EVENT) begin
				rdat_d[1:0] = ev_q;
			end else if (i_paddr == A_MASK) begin
				rdat_d[1:0] = msk_q;
			end else if (i_paddr == A_FAULT) begin
				rdat_d[2:0] = flt_q;
			end else begin
				err_d = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Sequencer, watchdog, retry and events
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		dest_d = dest_q;
		stk_d = tick ? stk_q + 1'b1 : stk_q;
		if (step) begin
			stk_d = '0;
		end
		sup_d = sup_q;
		sysen_d = sysen_q;
		crst_n_d = crst_n_q;
		aon_d = aon_q;
		frz_d = frz_q;
		rty_d = rty_q;
		wdt_d = wdt_q;
		msk_d = msk_q;
		ev_d = ev_q;
		flt_d = flt_q;
		if (wr && i_paddr == A_CTRL) begin
			sysen_d = i_pwdata[CTRL_SYSEN];
		end
		if (wr && i_paddr == A_MASK) begin
			msk_d = i_pwdata[1:0];
		end
		if (wr && i_paddr == A_EVENT) begin
			ev_d = ev_q & ~i_pwdata[1:0];
		end
		if (wr && i_paddr == A_FAULT) begin
			flt_d = flt_q & ~i_pwdata[2:0];
		end
		if (live && tick) begin
			wdt_d = wdt_q + 1'b1;
		end
		if (kick || !live) begin
			wdt_d = '0;
		end
		case (st_q)
			S_RESET: begin
				sup_d = '0;
				crst_n_d = 1'b0;
				sysen_d = 1'b0;
				aon_d = ~por;
				if (!crit && !por) begin
					st_d = S_OFF;
				end
			end
			S_OFF: begin
				if (wake && !frz_q) begin
					st_d = S_PUP1;
					sysen_d = 1'b1;
				end
			end
			S_PUP1: begin
				crst_n_d = 1'b1;
				if (pen) begin
					st_d = S_PUP2;
					stk_d = '0;
				end
			end
			S_PUP2: begin
				if (step) begin
					if (&sup_q) begin
						st_d = S_RUN;
					end else begin
						sup_d = {sup_q[NSUP-2:0], 1'b1};
					end
				end
			end
			S_RUN: begin
				if (kick) begin
					st_d = S_ACT;
				end
			end
			S_ACT: begin
			end
			// reverse order, one supply per step
			S_PDN: begin
				crst_n_d = 1'b0;
				sysen_d = 1'b0;
				if (step) begin
					if (sup_q == '0) begin
						st_d = dest_q ? S_RESET : S_OFF;
						if (dest_q) begin
							rty_d = RETRY_START;
							frz_d = 1'b0;
						end
					end else begin
						sup_d = {1'b0, sup_q[NSUP-1:1]};
					end
				end
			end
			default: begin
				st_d = S_RESET;
			end
		endcase
		if (powered && !sysen_d) begin
			st_d = S_PDN;
			dest_d = 1'b0;
			stk_d = '0;
			crst_n_d = 1'b0;
		end
		if (wdt_exp) begin
			flt_d[FL_WDT] = 1'b1;
			ev_d[EV_WDT] = 1'b1;
			sysen_d = 1'b0;
			st_d = S_PDN;
			dest_d = 1'b0;
			stk_d = '0;
			crst_n_d = 1'b0;
			if (rty_q != '0) begin
				rty_d = rty_q - 1'b1;
			end
			if (rty_q <= RETRY_W'(1)) begin
				frz_d = 1'b1;
			end
		end
		if (crit_rise) begin
			flt_d[FL_TCRIT] = 1'b1;
			if (st_q != S_RESET) begin
				st_d = S_PDN;
				dest_d = 1'b1;
				stk_d = '0;
				crst_n_d = 1'b0;
				sysen_d = 1'b0;
			end
		end
		// warning event, set wins over clear
		if (warn_rise) begin
			ev_d[EV_TWARN] = 1'b1;
		end
		if (wake_fall) begin
			rty_d = RETRY_START;
			frz_d = 1'b0;
		end
		if (por) begin
			st_d = S_RESET;
			sup_d = '0;
			aon_d = 1'b0;
			crst_n_d = 1'b0;
			sysen_d = 1'b0;
			flt_d[FL_POR] = 1'b1;
		end
		irq_n_d = ~|(ev_d & ~msk_q);
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= S_RESET;
			dest_q <= 1'b0;
			stk_q <= '0;
			sup_q <= '0;
			sysen_q <= 1'b0;
			crst_n_q <= 1'b0;
			aon_q <= 1'b0;
			frz_q <= 1'b0;
			rty_q <= RETRY_START;
			wdt_q <= '0;
			msk_q <= MASK_RST;
			ev_q <= '0;
			flt_q <= '0;
			irq_n_q <= 1'b1;
			fwd_q <= 1'b0;
			prv_q <= '0;
			rdat_q <= '0;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			st_q <= st_d;
			dest_q <= dest_d;
			stk_q <= stk_d;
			sup_q <= sup_d;
			sysen_q <= sysen_d;
			crst_n_q <= crst_n_d;
			aon_q <= aon_d;
			frz_q <= frz_d;
			rty_q <= rty_d;
			wdt_q <= wdt_d;
			msk_q <= msk_d;
			ev_q <= ev_d;
			flt_q <= flt_d;
			irq_n_q <= irq_n_d;
			fwd_q <= wake;
			prv_q <= {crit, warn, wake};
			rdat_q <= rdat_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
		end
	end

	assign o_prdata = rdat_q;
	assign o_pready = rdy_q;
	assign o_pslverr = err_q;
	assign o_forwarded_wake_output_pin = fwd_q;
	assign o_core_reset_output_pin_n = crst_n_q;
	assign o_supply_en = sup_q;
	assign o_always_on_regulator_en = aon_q;
	assign o_system_en = sysen_q;
	assign o_interrupt_request_out_n = irq_n_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	property p_wdt_err;
		wdt_exp && !por |=> st_q == S_PDN && !sysen_q && flt_q[FL_WDT] && !crst_n_q;
	endproperty
	a_wdt_err: assert property (p_wdt_err) else $error("watchdog expiry missed");
	property p_retry_dec;
		wdt_exp && rty_q != '0 && !wake_fall |=> rty_q == $past(rty_q) - 1'b1;
	endproperty
	a_retry_dec: assert property (p_retry_dec) else $error("retry not decremented");
	property p_freeze;
		wdt_exp && rty_q == RETRY_W'(1) && !wake_fall |=> frz_q;
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze not set");
	property p_restart;
		st_q == S_OFF && wake && !frz_q && !por && !crit_rise |=> st_q == S_PUP1 && sysen_q;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart from powerdown");
	property p_frozen;
		st_q == S_OFF && frz_q |=> st_q != S_PUP1;
	endproperty
	a_frozen: assert property (p_frozen) else $error("power-up while frozen");
	property p_wake_rel;
		wake_fall |=> !frz_q && rty_q == RETRY_START;
	endproperty
	a_wake_rel: assert property (p_wake_rel) else $error("wake release ignored");
	property p_active;
		st_q != S_ACT ##1 st_q == S_ACT |-> $past(kick) && $past(st_q) == S_RUN;
	endproperty
	a_active: assert property (p_active) else $error("active without kick");
	property p_irq;
		warn_rise && !msk_q[EV_TWARN] |=> !o_interrupt_request_out_n && ev_q[EV_TWARN];
	endproperty
	a_irq: assert property (p_irq) else $error("warning interrupt missing");
	property p_irq_rel;
		wr && i_paddr == A_EVENT && i_pwdata[1:0] == 2'h3 && !warn_rise && !wdt_exp |=> o_interrupt_request_out_n;
	endproperty
	a_irq_rel: assert property (p_irq_rel) else $error("interrupt not released");
	property p_tsd;
		crit_rise && st_q != S_RESET && !por |=> st_q == S_PDN && dest_q && flt_q[FL_TCRIT];
	endproperty
	a_tsd: assert property (p_tsd) else $error("critical shut-down missed");
	property p_tsd_end;
		st_q == S_PDN && dest_q && step && sup_q == '0 && !por && !crit_rise && flt_q[FL_TCRIT] && !wr
			|=> st_q == S_RESET && rty_q == RETRY_START && flt_q[FL_TCRIT];
	endproperty
	a_tsd_end: assert property (p_tsd_end) else $error("shut-down end wrong");
	property p_rst_hold;
		st_q == S_RESET && crit |=> st_q == S_RESET;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("left reset while critical");
	property p_por;
		por |=> st_q == S_RESET && !o_always_on_regulator_en && o_supply_en == '0;
	endproperty
	a_por: assert property (p_por) else $error("por reset missed");
	property p_pdn;
		st_q == S_PDN |=> !o_core_reset_output_pin_n && (o_supply_en & ~$past(o_supply_en)) == '0;
	endproperty
	a_pdn: assert property (p_pdn) else $error("power-down order broken");
	property p_wdt_hold;
		st_q == S_OFF |=> wdt_q == '0;
	endproperty
	a_wdt_hold: assert property (p_wdt_hold) else $error("watchdog counting in powerdown");

	property p_cv_freeze;
		wdt_exp && rty_q == RETRY_W'(1);
	endproperty
	c_freeze: cover property (p_cv_freeze);
	property p_cv_active;
		st_q == S_RUN ##1 st_q == S_ACT;
	endproperty
	c_active: cover property (p_cv_active);
	property p_cv_tsd;
		st_q == S_PDN && dest_q ##1 st_q == S_RESET;
	endproperty
	c_tsd: cover property (p_cv_tsd);
endmodule : pfr_seq

//--- tb/pfr_host_model.sv
module pfr_host_model import pfr_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_core_reset_n,
	output logic o_power_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] boot_q;
	// ------------------------------------------------------------
	// Core-on request
	// ------------------------------------------------------------
	// Core-on drops at once with core reset, rises a few cycles after boot
	always @(posedge i_sys_clk or negedge i_rst_n or negedge i_core_reset_n) begin
		if (!i_rst_n || !i_core_reset_n) begin
			boot_q <= 4'h0;
			o_power_enable <= 1'b0;
		end else if (boot_q != 4'h5) begin
			boot_q <= boot_q + 4'h1;
		end else begin
			o_power_enable <= 1'b1;
		end
	end
endmodule : pfr_host_model

//--- tb/tb_pfr_seq.sv
module tb_pfr_seq import pfr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, psel, penable, pwrite, wake, pen, warn, crit, por;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic pready, pslverr, fwd, core_n, aon, sen, irq_n, rs_q;
	logic [5:0] sup, sup_p;
	int error_cnt, n_checks;
	pfr_seq #(.TICK_CYCLES(10), .WDT_MAX(20)) uut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_wake_input_pin(wake), .i_power_enable_input_pin(pen),
		.i_temp_warn_cmp(warn), .i_temp_critical_threshold_cmp(crit), .i_temp_por_cmp(por),
		.o_forwarded_wake_output_pin(fwd), .o_core_reset_output_pin_n(core_n), .o_supply_en(sup),
		.o_always_on_regulator_en(aon), .o_system_en(sen), .o_interrupt_request_out_n(irq_n));
	pfr_host_model host (.i_sys_clk(clk), .i_rst_n(rst_n), .i_core_reset_n(core_n), .o_power_enable(pen));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Checking and bus tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Ready, read data and error are taken at the rising edge that completes the access
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				chk(32'h0, 32'h1);
				end_sim();
			end
			@(posedge clk);
		end
		rd_q = prdata;
		rs_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd_q & m, e);
	endtask : rd_chk
	task automatic wait_mode(input logic [6:0] m);
		int n;
		n = 0;
		apb(1'b0, A_STAT, 32'h0);
		while (rd_q[6:0] !== m) begin
			n++;
			if (n > 1500) begin
				chk(rd_q, {25'h0, m});
				end_sim();
			end
			apb(1'b0, A_STAT, 32'h0);
		end
	endtask : wait_mode
	task automatic boot();
		wait_mode(S_RUN);
		chk({26'h0, sup}, 32'h3F);
		rd_chk(A_STAT, 32'h7F, S_RUN);
		apb(1'b1, A_CTRL, 32'h3);
		wait_mode(S_ACT);
	endtask : boot
	// ------------------------------------------------------------
	// Supply order monitor
	// ------------------------------------------------------------
	// One supply at a time, always a contiguous block from bit 0
	always @(negedge clk) begin
		sup_p <= sup;
		if (rst_n && sup_p !== sup) begin
			chk({26'h0, ((sup ^ sup_p) & ((sup ^ sup_p) - 6'h1)) | (sup & (sup + 6'h1))}, 32'h0);
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, psel, penable, pwrite, wake, warn, crit, por} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		chk({30'h0, aon, irq_n}, 32'h3);
		rd_chk(A_STAT, 32'hFFFFFFFF, 32'h00000302);
		rd_chk(A_MASK, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, rs_q}, 32'h0);
		rd_chk(8'h14, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, rs_q}, 32'h1);
		wake <= 1'b1;
		wait_mode(S_PUP1);
		chk({30'h0, fwd, sen}, 32'h3);
		boot();
		// Three missed kicks: two restarts, then freeze
		for (int i = 0; i < 3; i++) begin
			wait_mode(S_PDN);
			chk({30'h0, sen, core_n}, 32'h0);
			rd_chk(A_STAT, 32'h1F00, {19'h0, i == 2, 4'(2 - i), 8'h0});
			rd_chk(A_FAULT, 32'h2, 32'h2);
			if (i < 2) begin
				wait_mode(S_RUN);
			end
		end
		wait_mode(S_OFF);
		repeat (300) @(posedge clk);
		rd_chk(A_STAT, 32'h7F, S_OFF);
		chk({31'h0, sen}, 32'h0);
		apb(1'b1, A_FAULT, 32'h7);
		rd_chk(A_FAULT, 32'h7, 32'h0);
		wake <= 1'b0;
		repeat (200) @(posedge clk);
		rd_chk(A_STAT, 32'h1F00, 32'h0300);
		chk({31'h0, fwd}, 32'h0);
		wake <= 1'b1;
		boot();
		// Warning event, mask, clear while the comparator stays high
		apb(1'b1, A_EVENT, 32'h3);
		warn <= 1'b1;
		repeat (10) @(posedge clk);
		chk({31'h0, irq_n}, 32'h0);
		rd_chk(A_EVENT, 32'h1, 32'h1);
		apb(1'b1, A_MASK, 32'h1);
		// Mask lands at the access edge, the interrupt pin follows one edge later
		repeat (2) @(posedge clk);
		chk({31'h0, irq_n}, 32'h1);
		apb(1'b1, A_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chk({31'h0, irq_n}, 32'h0);
		apb(1'b1, A_EVENT, 32'h1);
		repeat (10) @(posedge clk);
		chk({31'h0, irq_n}, 32'h1);
		// host throttles, die cools below warning
		warn <= 1'b0;
		apb(1'b1, A_CTRL, 32'h3);
		wake <= 1'b0;
		repeat (150) @(posedge clk);
		apb(1'b1, A_CTRL, 32'h0);
		wait_mode(S_OFF);
		repeat (100) @(posedge clk);
		rd_chk(A_STAT, 32'h7F, S_OFF);
		chk({26'h0, sup}, 32'h0);
		wake <= 1'b1;
		boot();
		wait_mode(S_PDN);
		boot();
		// Critical temperature shut-down from ACTIVE with retry at two
		crit <= 1'b1;
		wait_mode(S_PDN);
		rd_chk(A_FAULT, 32'h1, 32'h1);
		wait_mode(S_RESET);
		rd_chk(A_STAT, 32'h1F00, 32'h0300);
		rd_chk(A_FAULT, 32'h1, 32'h1);
		repeat (200) @(posedge clk);
		rd_chk(A_STAT, 32'h7F, S_RESET);
		crit <= 1'b0;
		wait_mode(S_PUP1);
		por <= 1'b1;
		repeat (8) @(posedge clk);
		chk({24'h0, aon, core_n, sup}, 32'h0);
		rd_chk(A_STAT, 32'h7F, S_RESET);
		por <= 1'b0;
		repeat (20) @(posedge clk);
		chk({31'h0, aon}, 32'h1);
		end_sim();
	end
endmodule : tb_pfr_seq
